// ---- hw/mrp_core.sv ----
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mrp_defs.svh"
// Behaviour
// - reset pin low, filtered, reset 1.5-4.0 ms
// - pins hi-z weak pull-down during reset
// - host link reset only by pin, power-on
// - four reset sources: pin, power, watchdog, host
// - regulator enable high powers core, else off
// - enable low pulse forces full power-on reset
// - coexistence and function 0 survive core off
// - software picks pull mode per io line
// - boot clocks first, crystal setting applied later
// - core clocks from crystal PLL, not sleep
// - sleep clock internal RC or external pin
module mrp_core #(
  parameter int NPIO = 6, // programmable io lines
  parameter int LF_DIV = `MRP_LF_DIV, // cycles per low-frequency tick
  parameter int FILT_TICKS = `MRP_FILT_TICKS // ticks of low pin before reset
) (
  input wire logic mclk_i, // 25 MHz clock, PLL derived
  input wire logic reset_n_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb write
  input wire logic [11:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic ext_rst_n_i, // external reset pin, active low
  input wire logic regulator_enable_input_i, // core regulator enable
  input wire logic core_supply_input_i, // core supply present
  input wire logic host_rst_req_i, // reset command from the host bus
  input wire logic [NPIO-1:0] programmable_io_line_i, // io line levels
  output logic [2*NPIO-1:0] pio_pull_o, // per line pull mode
  output logic pio_hiz_o, // io lines held in high impedance
  output logic rst_pin_pullup_o, // weak pull-up on the reset pin
  output logic dbg_cs_pullup_o, // weak pull-up on debug chip select
  output logic core_rst_n_o, // core reset, active low
  output logic host_if_rst_n_o, // host link reset, active low
  output logic core_reg_en_o, // core regulators enabled
  output logic aon_en_o, // coexistence and function 0 enable
  output logic boot_clk_sel_o, // safe boot clock selected
  output logic [7:0] xtal_cfg_o, // applied crystal setting
  output logic sleep_ext_sel_o, // external sleep clock in use
  output logic sleep_tick_o // sleep timer tick pulse
);
  // ==========================================================
  // pin synchronisers: three flops, change when two and three agree
  logic [2:0] rst_sync_reg;
  logic [2:0] en_sync_reg;
  logic [2:0] sup_sync_reg;
  logic [2:0] [NPIO-1:0] io_sync_reg;
  logic rst_low_reg;
  logic en_reg;
  logic sup_reg;
  logic [NPIO-1:0] io_reg;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 3'h7;
      en_sync_reg <= 3'h0;
      sup_sync_reg <= 3'h0;
      io_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], ext_rst_n_i};
      en_sync_reg <= {en_sync_reg[1:0], regulator_enable_input_i};
      sup_sync_reg <= {sup_sync_reg[1:0], core_supply_input_i};
      io_sync_reg <= {io_sync_reg[1:0], programmable_io_line_i};
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_low_reg <= 1'b0;
      en_reg <= 1'b0;
      sup_reg <= 1'b0;
      io_reg <= '0;
    end else begin
      if (rst_sync_reg[1] == rst_sync_reg[2]) rst_low_reg <= !rst_sync_reg[2];
      if (en_sync_reg[1] == en_sync_reg[2]) en_reg <= en_sync_reg[2];
      if (sup_sync_reg[1] == sup_sync_reg[2]) sup_reg <= sup_sync_reg[2];
      for (int i = 0; i < NPIO; i++) begin
        if (io_sync_reg[1][i] == io_sync_reg[2][i]) io_reg[i] <= io_sync_reg[2][i];
      end
    end
  end

  // ==========================================================
  // low-frequency oscillator tick from the system clock
  logic [15:0] lf_cnt_reg;
  logic lf_tick_w;
  assign lf_tick_w = (lf_cnt_reg == 16'(LF_DIV - 1));
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lf_cnt_reg <= 16'h0000;
    end else begin
      lf_cnt_reg <= lf_tick_w ? 16'h0000 : lf_cnt_reg + 16'h0001;
    end
  end

  mrp_rst_if rif ();
  assign rif.lf_tick = lf_tick_w;

  mrp_pin_filter #(
    .TICKS(FILT_TICKS)
  ) u_filt (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_low_i(rst_low_reg),
    .rif(rif)
  );

  // ==========================================================
  // registers
  logic [31:0] ctrl_reg;
  logic [31:0] pull_reg;
  logic [7:0] xtal_prog_reg;
  logic [3:0] cause_reg;
  logic [15:0] wdt_reg;
  logic wr_w;
  logic rd_hit_w;
  logic wr_ctrl_w;
  logic wr_cause_w;
  logic sw_rst_w;
  logic wdt_rst_w;
  logic por_w;
  logic warm_rst_w;
  assign wr_w = psel_i && penable_i && pwrite_i;
  assign wr_ctrl_w = wr_w && (paddr_i == `MRP_OFF_CTRL);
  assign wr_cause_w = wr_w && (paddr_i == `MRP_OFF_CAUSE);
  assign rd_hit_w = (paddr_i == `MRP_OFF_CTRL) || (paddr_i == `MRP_OFF_STATUS) ||
                    (paddr_i == `MRP_OFF_PULL) || (paddr_i == `MRP_OFF_XTAL) ||
                    (paddr_i == `MRP_OFF_CAUSE);
  assign sw_rst_w = host_rst_req_i || (wr_ctrl_w && pwdata_i[`MRP_CTRL_SW_RST]);
  assign wdt_rst_w = ctrl_reg[`MRP_CTRL_WDT_EN] && (wdt_reg == 16'h0000);
  assign por_w = !en_reg || !sup_reg;
  assign warm_rst_w = sw_rst_w || wdt_rst_w;

  // ==========================================================
  // power and reset sequencer
  mrp_pkg::mrp_state_t st_reg;
  mrp_pkg::mrp_state_t st_next;
  logic [7:0] boot_cnt_reg;
  logic host_rst_reg;
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      mrp_pkg::MRP_ST_OFF: if (!por_w) st_next = mrp_pkg::MRP_ST_RESET;
      mrp_pkg::MRP_ST_RESET: if (!rif.pin_rst) st_next = mrp_pkg::MRP_ST_BOOT;
      mrp_pkg::MRP_ST_BOOT: if (boot_cnt_reg == 8'(`MRP_BOOT_CYCLES)) begin
        st_next = mrp_pkg::MRP_ST_RUN;
      end
      mrp_pkg::MRP_ST_RUN: if (rif.pin_rst || warm_rst_w) st_next = mrp_pkg::MRP_ST_RESET;
    endcase
    if (por_w) st_next = mrp_pkg::MRP_ST_OFF;
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= mrp_pkg::MRP_ST_OFF;
      boot_cnt_reg <= 8'h00;
      host_rst_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      boot_cnt_reg <= (st_reg == mrp_pkg::MRP_ST_BOOT) ? boot_cnt_reg + 8'h01 : 8'h00;
      if (por_w || rif.pin_rst) host_rst_reg <= 1'b1;
      else if (st_reg != mrp_pkg::MRP_ST_OFF) host_rst_reg <= 1'b0;
    end
  end

  // ==========================================================
  // register writes; every core reset clears all registers but cause and reloads the watchdog count with FFFF
  logic in_rst_w;
  assign in_rst_w = (st_reg == mrp_pkg::MRP_ST_OFF) || (st_reg == mrp_pkg::MRP_ST_RESET);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `MRP_CTRL_RESET;
      pull_reg <= `MRP_PULL_RESET;
      xtal_prog_reg <= 8'h00;
      wdt_reg <= 16'hFFFF;
    end else if (in_rst_w) begin
      ctrl_reg <= `MRP_CTRL_RESET;
      pull_reg <= `MRP_PULL_RESET;
      xtal_prog_reg <= 8'h00;
      wdt_reg <= 16'hFFFF;
    end else begin
      if (wr_ctrl_w) ctrl_reg <= pwdata_i & 32'hFFFF_FFFE;
      if (wr_w && paddr_i == `MRP_OFF_PULL) pull_reg <= pwdata_i;
      if (wr_w && paddr_i == `MRP_OFF_XTAL) xtal_prog_reg <= pwdata_i[7:0];
      if (wr_ctrl_w && pwdata_i[`MRP_CTRL_WDT_KICK]) begin
        wdt_reg <= pwdata_i[`MRP_CTRL_WDT_LSB +: 16];
      end else if (ctrl_reg[`MRP_CTRL_WDT_EN] && wdt_reg != 16'h0000 && lf_tick_w) begin
        wdt_reg <= wdt_reg - 16'h0001;
      end
    end
  end

  // cause bits: hardware set wins over software clear
  logic [3:0] cause_set_w;
  assign cause_set_w = {sw_rst_w && st_reg == mrp_pkg::MRP_ST_RUN,
                        wdt_rst_w && st_reg == mrp_pkg::MRP_ST_RUN, por_w, rif.pin_rst};
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cause_reg <= 4'h2;
    end else begin
      cause_reg <= (cause_reg & ~(wr_cause_w ? pwdata_i[3:0] : 4'h0)) | cause_set_w;
    end
  end

  // ==========================================================
  // outputs
  logic [31:0] status_w;
  assign status_w = {20'h00000, 6'(io_reg), 2'(st_reg),
                     rst_low_reg, en_reg, sup_reg, sleep_ext_sel_o};
  assign prdata_o = !rd_hit_w ? 32'h0000_0000 :
                    (paddr_i == `MRP_OFF_CTRL) ? ctrl_reg :
                    (paddr_i == `MRP_OFF_STATUS) ? status_w :
                    (paddr_i == `MRP_OFF_PULL) ? pull_reg :
                    (paddr_i == `MRP_OFF_XTAL) ? {24'h000000, xtal_prog_reg} :
                    {28'h0000000, cause_reg};
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !rd_hit_w;

  assign pio_pull_o = in_rst_w ? '0 : pull_reg[2*NPIO-1:0];
  assign pio_hiz_o = in_rst_w;
  assign rst_pin_pullup_o = 1'b1;
  assign dbg_cs_pullup_o = 1'b1;
  assign core_rst_n_o = !in_rst_w;
  assign host_if_rst_n_o = !host_rst_reg;
  assign core_reg_en_o = en_reg;
  assign aon_en_o = 1'b1;
  assign boot_clk_sel_o = (st_reg != mrp_pkg::MRP_ST_RUN);
  assign xtal_cfg_o = boot_clk_sel_o ? 8'h00 : xtal_prog_reg;

  // ==========================================================
  // sleep clock: internal tick or external square wave on a chosen line
  logic [2:0] clkpin_w;
  logic ext_lvl_reg;
  logic [7:0] io_pad_w;
  // line codes without a line read low, so no out-of-range select
  assign io_pad_w = 8'(io_reg);
  assign clkpin_w = ctrl_reg[`MRP_CTRL_CLKPIN_LSB +: 3];
  assign sleep_ext_sel_o = ctrl_reg[`MRP_CTRL_EXT_SLEEP];
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_lvl_reg <= 1'b0;
      sleep_tick_o <= 1'b0;
    end else begin
      ext_lvl_reg <= io_pad_w[clkpin_w];
      sleep_tick_o <= sleep_ext_sel_o ? (io_pad_w[clkpin_w] && !ext_lvl_reg) : lf_tick_w;
    end
  end
endmodule // mrp_core

// ---- hw/mrp_defs.svh ----
`ifndef MRP_DEFS_SVH
`define MRP_DEFS_SVH

// ==========================================================
// clock and timing
`define MRP_CLK_HZ 25000000
`define MRP_LF_HZ 32768
`define MRP_FILT_MIN_US 1500
`define MRP_FILT_MAX_US 4000
// low-frequency ticks the reset pin must stay low: 1.5 ms rounded up,
// plus one because the first tick lands anywhere in its period
`define MRP_FILT_TICKS ((`MRP_FILT_MIN_US * `MRP_LF_HZ + 999999) / 1000000 + 1)
// divider from 25 MHz to the internal low-frequency tick
`define MRP_LF_DIV (`MRP_CLK_HZ / `MRP_LF_HZ)
// boot counter value that ends boot: 17 boot clock cycles before the programmed crystal setting is applied
`define MRP_BOOT_CYCLES 16

// ==========================================================
// register byte offsets
`define MRP_OFF_CTRL 12'h000
`define MRP_OFF_STATUS 12'h004
`define MRP_OFF_PULL 12'h008
`define MRP_OFF_XTAL 12'h00C
`define MRP_OFF_CAUSE 12'h010

// ==========================================================
// control fields
`define MRP_CTRL_SW_RST 0
`define MRP_CTRL_WDT_EN 1
`define MRP_CTRL_WDT_KICK 2
`define MRP_CTRL_EXT_SLEEP 3
`define MRP_CTRL_CLKPIN_LSB 4
`define MRP_CTRL_WDT_LSB 8
`define MRP_CTRL_RESET 32'h0000_0000
`define MRP_PULL_RESET 32'h0000_0000
`define MRP_XTAL_RESET 32'h0000_0000

// cause bits
`define MRP_CAUSE_PIN 0
`define MRP_CAUSE_POR 1
`define MRP_CAUSE_WDT 2
`define MRP_CAUSE_HOST 3

`endif

// ---- hw/mrp_pin_filter.sv ----
`timescale 1ns/1ps
`include "mrp_defs.svh"
// ==========================================================
// counts low-frequency ticks while the synchronised pin stays low
module mrp_pin_filter #(
  parameter int TICKS = `MRP_FILT_TICKS
) (
  input wire logic mclk_i, // system clock
  input wire logic reset_n_i, // async reset
  input wire logic pin_low_i, // synchronised pin level is low
  mrp_rst_if.filt rif // tick in, reset request out
);
  logic [15:0] cnt_reg;
  logic done_w;
  assign done_w = (cnt_reg == 16'(TICKS));
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 16'h0000;
    end else if (!pin_low_i) begin
      cnt_reg <= 16'h0000;
    end else if (rif.lf_tick && !done_w) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign rif.pin_rst = done_w && pin_low_i;
endmodule // mrp_pin_filter

// ---- hw/mrp_pkg.sv ----
package mrp_pkg;
  typedef enum logic [1:0] {
    MRP_PULL_WEAK_DN = 2'b00,
    MRP_PULL_WEAK_UP = 2'b01,
    MRP_PULL_STRONG_DN = 2'b10,
    MRP_PULL_STRONG_UP = 2'b11
  } mrp_pull_t;

  typedef enum logic [1:0] {
    MRP_ST_OFF = 2'b00,
    MRP_ST_RESET = 2'b01,
    MRP_ST_BOOT = 2'b10,
    MRP_ST_RUN = 2'b11
  } mrp_state_t;
endpackage

// ---- hw/mrp_rst_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// reset request from the pin filter to the sequencer
interface mrp_rst_if;
  logic lf_tick;
  logic pin_rst;
  modport filt (input lf_tick, output pin_rst);
  modport seq (output lf_tick, input pin_rst);
endinterface

// ---- verification/mrp_core_sva.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checker of the sequencer
module mrp_core_sva #(parameter int NPIO = 6) (
  input wire logic mclk_i, // clock
  input wire logic reset_n_i, // reset
  input wire logic ext_rst_n_i, // pin
  input wire logic regulator_enable_input_i, // enable
  input wire logic host_rst_req_i, // host req
  input wire logic [2*NPIO-1:0] pio_pull_o, // pulls
  input wire logic pio_hiz_o, // hi-z
  input wire logic rst_pin_pullup_o, // pull-up
  input wire logic dbg_cs_pullup_o, // pull-up
  input wire logic core_rst_n_o, // core reset
  input wire logic host_if_rst_n_o, // link reset
  input wire logic core_reg_en_o, // regulators
  input wire logic aon_en_o, // always-on
  input wire logic boot_clk_sel_o, // boot clock
  input wire logic [7:0] xtal_cfg_o // crystal
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // assertions
  pad_pullup_a: assert property (rst_pin_pullup_o && dbg_cs_pullup_o && aon_en_o)
    else $error("pull-up or always-on dropped");
  reset_pads_a: assert property (!core_rst_n_o && !$past(core_rst_n_o) |->
    pio_hiz_o && pio_pull_o == '0) else $error("pads not safe in reset");
  boot_clock_a: assert property (!core_rst_n_o && !$past(core_rst_n_o) |->
    boot_clk_sel_o && xtal_cfg_o == 8'h00) else $error("boot clock not safe");
  regulator_enable_input_off_a: assert property ($fell(regulator_enable_input_i) |->
    ##[1:6] !core_reg_en_o) else $error("regulators stay on");
  regulator_enable_input_por_a: assert property ($fell(regulator_enable_input_i) |->
    ##[1:10] !core_rst_n_o) else $error("no power-on reset");
  filter_min_a: assert property ($fell(ext_rst_n_i) && core_rst_n_o ##1
    (!ext_rst_n_i) [*8] |-> core_rst_n_o) else $error("pin reset too early");
  filter_max_a: assert property ($fell(ext_rst_n_i) |->
    ##[1:40] (!core_rst_n_o || ext_rst_n_i)) else $error("pin reset too late");
  pin_link_a: assert property ($fell(ext_rst_n_i) |->
    ##[1:44] (!host_if_rst_n_o || ext_rst_n_i)) else $error("link kept on pin reset");
  warm_keep_a: assert property ($rose(host_rst_req_i) && host_if_rst_n_o |=>
    host_if_rst_n_o [*8]) else $error("link reset by host request");
  host_req_a: assert property ($rose(host_rst_req_i) |-> ##[1:8] !core_rst_n_o)
    else $error("host request ignored");
  cover property ($fell(core_rst_n_o) && host_if_rst_n_o);
  cover property ($fell(host_if_rst_n_o));
  cover property ($rose(core_rst_n_o));
endmodule // mrp_core_sva
bind mrp_core mrp_core_sva #(.NPIO(NPIO)) u_sva (.*);

// ---- verification/mrp_core_tb.sv ----
`timescale 1ns/1ps
`include "mrp_defs.svh"
module mrp_core_tb;
  logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i, pio_pull_o;
  logic [31:0] pwdata_i, prdata_o;
  logic ext_rst_n_i, regulator_enable_input_i, core_supply_input_i, host_rst_req_i;
  logic [5:0] programmable_io_line_i;
  logic pio_hiz_o, rst_pin_pullup_o, dbg_cs_pullup_o, core_rst_n_o, host_if_rst_n_o;
  logic core_reg_en_o, aon_en_o, boot_clk_sel_o, sleep_ext_sel_o, sleep_tick_o;
  logic [7:0] xtal_cfg_o;
  logic [15:0] lf = 16'h75A3;
  logic [31:0] regm [int];
  int mismatches = 0, n_tests = 0, hl_cnt = 0, cr_cnt = 0;
  mrp_core #(.NPIO(6), .LF_DIV(4), .FILT_TICKS(3)) DUT (.*);
  mrp_host_model HOST (.mclk_i(mclk_i), .ext_rst_n_o(ext_rst_n_i),
    .regulator_enable_input_o(regulator_enable_input_i), .supply_o(core_supply_input_i), .req_o(host_rst_req_i));
  always #20 mclk_i = ~mclk_i;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge mclk_i) begin
    lf <= lfsr_next(lf);
    programmable_io_line_i <= lf[5:0];
  end
  always @(negedge mclk_i) begin
    if (host_if_rst_n_o === 1'b0) hl_cnt++;
    if (core_rst_n_o === 1'b0) cr_cnt++;
  end
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) begin
      @(posedge mclk_i);
    end
    r = prdata_o;
    e = pslverr_o;
    if (w && e === 1'b0) regm[a] = d;
    {psel_i, penable_i} <= 2'h0;
  endtask
  task automatic wait_core();
    int k;
    k = 0;
    while (core_rst_n_o !== 1'b1 && k < 400) begin
      @(posedge mclk_i);
      k++;
    end
    chk1(core_rst_n_o, 1'b1);
  endtask
  task automatic do_rst(input int kind, input logic hl_exp);
    int c, h, k;
    logic [31:0] r;
    logic e;
    {c, h, k} = {cr_cnt, hl_cnt, 32'h0};
    case (kind)
      0: HOST.pin_low(48);
      1: HOST.req_pulse();
      2: HOST.power_cut(1'b0);
      3: HOST.power_cut(1'b1);
      4: apb(1'b1, `MRP_OFF_CTRL, 32'h0000_0001, r, e);
      default: apb(1'b1, `MRP_OFF_CTRL, 32'h0000_0406, r, e);
    endcase
    while (cr_cnt == c && k < 400) begin
      @(posedge mclk_i);
      k++;
    end
    wait_core();
    repeat (20) @(posedge mclk_i);
    chk1(cr_cnt != c, 1'b1);
    chk1(hl_cnt != h, hl_exp);
    regm[`MRP_OFF_PULL] = `MRP_PULL_RESET;
    apb(1'b0, `MRP_OFF_PULL, 32'h0, r, e);
    chk32(r, regm[`MRP_OFF_PULL]);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    conclude();
  end
  initial begin
    logic [31:0] r, v;
    logic e;
    int c;
    {mclk_i, reset_n_i, psel_i, penable_i, pwrite_i} = 5'h00;
    {paddr_i, pwdata_i} = 44'h0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wait_core();
    v = {24'h0, lf[7:0]};
    apb(1'b1, `MRP_OFF_XTAL, v, r, e);
    @(negedge mclk_i);
    chk1(boot_clk_sel_o, 1'b1);
    chk32({24'h0, xtal_cfg_o}, 32'h0);
    chk1(sleep_ext_sel_o, 1'b0);
    repeat (24) @(negedge mclk_i);
    chk1(boot_clk_sel_o, 1'b0);
    chk32({24'h0, xtal_cfg_o}, v);
    for (int m = 0; m < 4; m++) begin
      v = {20'h0, {6{m[1:0]}}};
      apb(1'b1, `MRP_OFF_PULL, v, r, e);
      @(negedge mclk_i);
      chk32({20'h0, pio_pull_o}, v);
      apb(1'b0, `MRP_OFF_PULL, 32'h0, r, e);
      chk32(r, regm[`MRP_OFF_PULL]);
    end
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, `MRP_OFF_CTRL, {28'h0, s[0], 3'h0}, r, e);
      @(negedge mclk_i);
      chk1(sleep_ext_sel_o, s[0]);
    end
    // internal sleep clock: one tick per four cycles with the bench divider
    v = 32'h0;
    repeat (40) begin
      @(negedge mclk_i);
      v = v + 32'(sleep_tick_o);
    end
    chk32(v, 32'h0000_000A);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    c = cr_cnt;
    HOST.pin_low(6);
    repeat (40) @(posedge mclk_i);
    chk1(cr_cnt == c, 1'b1);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `MRP_OFF_PULL, {20'h0, lf[11:0]}, r, e);
      do_rst(k, k == 0 || k == 2 || k == 3);
    end
    apb(1'b0, `MRP_OFF_CAUSE, 32'h0, r, e);
    chk32(r, 32'h0000_000F);
    apb(1'b0, `MRP_OFF_STATUS, 32'h0, r, e);
    chk32(r & 32'hFFFF_F03F, 32'h0000_0036);
    apb(1'b1, `MRP_OFF_CAUSE, 32'h0000_000F, r, e);
    apb(1'b0, `MRP_OFF_CAUSE, 32'h0, r, e);
    chk32(r, 32'h0000_0000);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wait_core();
    apb(1'b0, `MRP_OFF_CAUSE, 32'h0, r, e);
    chk32(r, 32'h0000_0002);
    apb(1'b0, `MRP_OFF_PULL, 32'h0, r, e);
    chk32(r, 32'h0000_0000);
    conclude();
  end
endmodule // mrp_core_tb

// ---- verification/mrp_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// host side driving reset pin, regulator enable and supply
module mrp_host_model (
  input wire logic mclk_i, // clock
  output logic ext_rst_n_o, // reset pin
  output logic regulator_enable_input_o, // regulator enable
  output logic supply_o, // core supply
  output logic req_o // host reset command
);
  initial {ext_rst_n_o, regulator_enable_input_o, supply_o, req_o} = 4'hE;
  task automatic pin_low(input int n);
    @(posedge mclk_i);
    ext_rst_n_o <= 1'b0;
    repeat (n) @(posedge mclk_i);
    ext_rst_n_o <= 1'b1;
  endtask
  task automatic req_pulse();
    @(posedge mclk_i);
    req_o <= !req_o;
    @(posedge mclk_i);
    req_o <= !req_o;
  endtask
  // low pulse on enable or a supply cut
  task automatic power_cut(input logic sup);
    @(posedge mclk_i);
    supply_o <= !sup;
    regulator_enable_input_o <= sup;
    repeat (8) @(posedge mclk_i);
    {regulator_enable_input_o, supply_o} <= 2'h3;
  endtask
endmodule // mrp_host_model
